// ### logic/ict_top.sv
// Three channel interval counter timer with APB register access
//
// Contract
// RULE1 - Force low: mode 0, count not loaded
// RULE2 - Force high: mode 2, count not loaded
// RULE3 - Mode codes zero to five accepted
// RULE4 - Mode 0: output low, counts while gate high
// RULE5 - Mode 0: output high at zero, held
// RULE6 - Mode 1: low after gate rise, high at zero
// RULE7 - Mode 2: one clock low pulse per count
// RULE8 - Mode 3: square wave, halves of count
// RULE9 - Mode 4: output high, counts while gate high
// RULE10 - Mode 4: one clock low at terminal count
// RULE11 - Mode 5: gate rise triggers the countdown
// RULE12 - Host keeps counts within format range
// RULE13 - Host avoids count one in modes 2, 3
// RULE14 - Zero count means full range
// RULE15 - Count loads on next clock falling edge
// RULE16 - Format bit: 0 BCD, 1 binary
// RULE17 - Three counters, index 0 to 2
// RULE18 - Live count readable without disturbance
// RULE19 - Decrement on count clock falling edges
// RULE20 - Modes 2, 3 reload at terminal count
// RULE21 - BCD decades borrow and wrap to nine
`timescale 1ns/1ps
module ict_top
  import ict_pkg::*;
#(
  parameter int NUM_CTR = `ICT_NUM_CTR
)
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_CTR-1:0] count_clk_pin,
  input  wire logic [NUM_CTR-1:0] gate_input,
  output logic      [NUM_CTR-1:0] counter_out
);
  import ict_pkg::*;

  ict_top_state_t   s;
  ict_top_state_t   next_s;
  logic [NUM_CTR-1:0] clk_fall;
  logic [NUM_CTR-1:0] gate_rise;
  logic [NUM_CTR-1:0] gate_level;

  // ****************************************
  // Pin conditioning per counter
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CTR; gi++)
    begin : g_pin
      ict_pin_if pif ();
      ict_pin_cond u_cond (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .count_clk_pin (count_clk_pin[gi]),
        .gate_pin      (gate_input[gi]),
        .pins          (pif.producer)
      );
      assign clk_fall[gi]   = pif.clk_fall;
      assign gate_rise[gi]  = pif.gate_rise;
      assign gate_level[gi] = pif.gate_level;
      assign counter_out[gi] = s.ch[gi].out;
    end
  endgenerate

  // ****************************************
  // Down-count step
  // ****************************************
  // One nibble loop serves both formats: a binary nibble wraps to F
  function automatic logic [15:0] ict_dec(input logic [15:0] v, input logic fmt);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      if (borrow)
      begin
        if (r[4*k +: 4] == 4'h0)
          r[4*k +: 4] = (fmt == `ICT_FMT_BCD) ? `ICT_BCD_TOP : `ICT_BIN_TOP; // RULE21 RULE16
        else
        begin
          r[4*k +: 4] = r[4*k +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    ict_chan_t   c;
    logic [15:0] nx;
    logic [1:0]  idx;
    logic [3:0]  off;
    logic        hit;
    logic        wr;
    c      = '0;
    nx     = '0;
    idx    = paddr[`ICT_IDX_MSB:`ICT_IDX_LSB];
    off    = paddr[`ICT_OFF_MSB:0];
    hit    = (paddr[`ICT_HI_MSB:`ICT_HI_LSB] == 2'h0) && (32'(idx) < NUM_CTR) // RULE17
             && (paddr[1:0] == 2'h0);
    wr     = psel & penable & s.pready & pwrite;
    next_s = s;

    // Counting engine, one pass per counter
    for (int i = 0; i < NUM_CTR; i++)
    begin
      c  = s.ch[i];
      nx = ict_dec(c.cnt, c.fmt); // RULE14
      if (gate_rise[i])
        c.trig = 1'b1;
      if (clk_fall[i])
      begin
        if (c.pend)
        begin
          // Written count enters the counter on this falling edge
          c.cnt    = c.reload; // RULE15
          c.pend   = 1'b0;
          c.loaded = 1'b1;
          c.run    = (c.mode != `ICT_MODE_ONE) && (c.mode != `ICT_MODE_HWS);
          c.trig   = 1'b0;
        end
        else if (c.loaded)
        begin
          if (c.trig && (c.mode == `ICT_MODE_ONE || c.mode == `ICT_MODE_HWS))
          begin
            c.cnt  = c.reload; // RULE11
            c.run  = 1'b1;
            c.trig = 1'b0;
            if (c.mode == `ICT_MODE_ONE)
              c.out = 1'b0; // RULE6
            else
              c.out = 1'b1;
          end
          else
          begin
            c.trig = 1'b0;
            unique case (c.mode)
              `ICT_MODE_TC:
              begin
                if (gate_level[i])
                begin
                  c.cnt = nx; // RULE4
                  if (nx == `ICT_ZERO_COUNT)
                    c.out = 1'b1; // RULE5
                end
              end
              `ICT_MODE_ONE:
              begin
                if (c.run)
                begin
                  c.cnt = nx;
                  if (nx == `ICT_ZERO_COUNT)
                  begin
                    c.out = 1'b1; // RULE6
                    c.run = 1'b0;
                  end
                end
              end
              `ICT_MODE_RATE:
              begin
                if (gate_level[i])
                begin
                  if (c.cnt == `ICT_ONE_COUNT)
                  begin
                    c.cnt = c.reload; // RULE20
                    c.out = 1'b1; // RULE7
                  end
                  else
                  begin
                    c.cnt = nx;
                    if (nx == `ICT_ONE_COUNT)
                      c.out = 1'b0; // RULE7
                  end
                end
              end
              `ICT_MODE_SQR:
              begin
                // Steps of two; an odd count gives equal halves rounded up
                if (gate_level[i])
                begin
                  if (c.cnt == `ICT_TWO_COUNT || c.cnt == `ICT_ONE_COUNT)
                  begin
                    c.cnt = c.reload; // RULE20
                    c.out = ~c.out; // RULE8
                  end
                  else
                    c.cnt = ict_dec(nx, c.fmt); // RULE8
                end
              end
              `ICT_MODE_SWS, `ICT_MODE_HWS:
              begin
                if (!c.out)
                  c.out = 1'b1; // RULE10
                if (c.run && (c.mode == `ICT_MODE_HWS || gate_level[i])) // RULE9
                begin
                  c.cnt = nx;
                  if (nx == `ICT_ZERO_COUNT)
                  begin
                    c.out = 1'b0; // RULE10
                    c.run = 1'b0;
                  end
                end
              end
              default:
              begin
                c.run = 1'b0;
              end
            endcase
          end
        end
      end

      // Register writes take effect at the completing APB edge
      if (wr && hit && (32'(idx) == i))
      begin
        unique case (off)
          `ICT_OFF_CONFIG:
          begin
            c.mode   = pwdata[`ICT_CFG_MODE_MSB:`ICT_CFG_MODE_LSB]; // RULE3
            c.fmt    = pwdata[`ICT_CFG_FMT_BIT]; // RULE16
            c.out    = (c.mode != `ICT_MODE_TC); // RULE4 RULE9
            c.pend   = 1'b0;
            c.loaded = 1'b0;
            c.run    = 1'b0;
            c.trig   = 1'b0;
          end
          `ICT_OFF_COUNT:
          begin
            c.reload = pwdata[15:0];
            c.pend   = 1'b1; // RULE15
          end
          `ICT_OFF_FORCE:
          begin
            // No count is loaded, so the forced level holds indefinitely
            c.mode   = pwdata[`ICT_FORCE_BIT] ? `ICT_MODE_RATE : `ICT_MODE_TC; // RULE1 RULE2
            c.out    = pwdata[`ICT_FORCE_BIT];
            c.pend   = 1'b0;
            c.loaded = 1'b0;
            c.run    = 1'b0;
            c.trig   = 1'b0;
          end
          default:
          begin
            c.trig = c.trig;
          end
        endcase
      end
      next_s.ch[i] = c;
    end

    // APB slave: one wait state, then pready
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = ~hit;
      next_s.prdata  = 32'h0000_0000;
      if (hit && !pwrite)
      begin
        c = s.ch[idx];
        unique case (off)
          `ICT_OFF_CONFIG:
          begin
            next_s.prdata[`ICT_CFG_MODE_MSB:`ICT_CFG_MODE_LSB] = c.mode;
            next_s.prdata[`ICT_CFG_FMT_BIT]                    = c.fmt;
          end
          `ICT_OFF_COUNT:
            next_s.prdata[15:0] = c.reload;
          `ICT_OFF_FORCE:
            next_s.prdata[`ICT_FORCE_BIT] = c.out;
          `ICT_OFF_READ:
          begin
            // Copy of the live counter; counting is untouched
            next_s.prdata[15:0]             = c.cnt; // RULE18
            next_s.prdata[`ICT_RD_OUT_BIT]  = c.out;
            next_s.prdata[`ICT_RD_LOAD_BIT] = c.loaded;
          end
          default:
            next_s.prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '0;
      for (int i = 0; i < NUM_CTR; i++)
      begin
        s.ch[i].mode   <= `ICT_RST_MODE;
        s.ch[i].fmt    <= `ICT_RST_FMT;
        s.ch[i].out    <= `ICT_RST_OUT;
        s.ch[i].reload <= `ICT_RST_COUNT;
      end
    end
    else
      s <= next_s;
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
endmodule

// ### logic/ict_defines.svh
// Register map, field positions and reset values of the interval counter timer
`ifndef ICT_DEFINES_SVH
`define ICT_DEFINES_SVH
`define ICT_NUM_CTR      3
`define ICT_IDX_MSB      5
`define ICT_IDX_LSB      4
`define ICT_OFF_MSB      3
`define ICT_HI_MSB       7
`define ICT_HI_LSB       6
`define ICT_OFF_CONFIG   4'h0
`define ICT_OFF_COUNT    4'h4
`define ICT_OFF_FORCE    4'h8
`define ICT_OFF_READ     4'hC
`define ICT_CFG_MODE_MSB 2
`define ICT_CFG_MODE_LSB 0
`define ICT_CFG_FMT_BIT  3
`define ICT_FORCE_BIT    0
`define ICT_RD_OUT_BIT   16
`define ICT_RD_LOAD_BIT  17
`define ICT_FMT_BCD      1'b0
`define ICT_FMT_BIN      1'b1
`define ICT_MODE_TC      3'h0
`define ICT_MODE_ONE     3'h1
`define ICT_MODE_RATE    3'h2
`define ICT_MODE_SQR     3'h3
`define ICT_MODE_SWS     3'h4
`define ICT_MODE_HWS     3'h5
`define ICT_RST_MODE     3'h2
`define ICT_RST_FMT      1'b1
`define ICT_RST_OUT      1'b1
`define ICT_RST_COUNT    16'h0000
`define ICT_BCD_TOP      4'h9
`define ICT_BIN_TOP      4'hF
`define ICT_ZERO_COUNT   16'h0000
`define ICT_ONE_COUNT    16'h0001
`define ICT_TWO_COUNT    16'h0002
`endif

// ### logic/ict_pkg.sv
// Types shared by the interval counter timer modules
package ict_pkg;
  `include "ict_defines.svh"

  typedef logic [2:0] ict_mode_t;

  typedef struct packed {
    ict_mode_t   mode;
    logic        fmt;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic        out;
    logic        pend;
    logic        loaded;
    logic        run;
    logic        trig;
  } ict_chan_t;

  typedef struct packed {
    ict_chan_t [`ICT_NUM_CTR-1:0] ch;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } ict_top_state_t;

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] gate_sync;
    logic       clk_prev;
    logic       gate_prev;
    logic       clk_fall;
    logic       gate_rise;
  } ict_pin_state_t;
endpackage

// ### logic/ict_pin_if.sv
// Conditioned count clock and gate events of one counter
`timescale 1ns/1ps
interface ict_pin_if;
  logic clk_fall;
  logic gate_rise;
  logic gate_level;
  modport producer (output clk_fall, output gate_rise, output gate_level);
  modport consumer (input clk_fall, input gate_rise, input gate_level);
endinterface

// ### logic/ict_pin_cond.sv
// Synchroniser and edge detector for one counter's clock and gate pins
`timescale 1ns/1ps
module ict_pin_cond
  import ict_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  reset,
  input  wire logic  count_clk_pin,
  input  wire logic  gate_pin,
  ict_pin_if.producer pins
);
  ict_pin_state_t s;
  ict_pin_state_t next_s;

  // ****************************************
  // Edge detection
  // ****************************************
  always_comb
  begin
    next_s              = s;
    next_s.clk_sync     = {s.clk_sync[0], count_clk_pin};
    next_s.gate_sync    = {s.gate_sync[0], gate_pin};
    next_s.clk_prev     = s.clk_sync[1];
    next_s.gate_prev    = s.gate_sync[1];
    // Counting happens on the falling edge of the count clock
    next_s.clk_fall     = s.clk_prev & ~s.clk_sync[1]; // RULE19
    next_s.gate_rise    = ~s.gate_prev & s.gate_sync[1];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign pins.clk_fall   = s.clk_fall;
  assign pins.gate_rise  = s.gate_rise;
  assign pins.gate_level = s.gate_prev;
endmodule

// ### verif/ict_sva.sv
// Bus and output checker of the interval counter timer
`timescale 1ns/1ps
module ict_sva
  import ict_pkg::*;
#(
  parameter int NUM_CTR = 3
)
(
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [NUM_CTR-1:0] count_clk_pin,
  input wire logic [NUM_CTR-1:0] gate_input,
  input wire logic [NUM_CTR-1:0] counter_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire acc = psel && penable && !pready;
  wire ok  = paddr[7:6] == 2'h0 && paddr[5:4] != 2'h3;
  wire wd  = psel && penable && pready && pwrite && ok;
  // ****************
  // Bus
  // ****************
  a_ready_after: assert property (acc |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
  a_bad_addr: assert property (acc && !ok |=> pslverr) else $error("no error");
  a_good_addr: assert property (acc && ok && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("false error");
  // ****************
  // Output levels
  // ****************
  a_force_low: assert property (wd && paddr[3:0] == 4'h8 && !pwdata[0]
    |=> !counter_out[$past(paddr[5:4])]) else $error("not low");
  a_force_high: assert property (wd && paddr[3:0] == 4'h8 && pwdata[0]
    |=> counter_out[$past(paddr[5:4])]) else $error("not high");
  a_cfg_level: assert property (wd && paddr[3:0] == 4'h0
    |=> counter_out[$past(paddr[5:4])] == ($past(pwdata[2:0]) != 3'h0))
    else $error("bad config level");
  c_force: cover property (wd && paddr[3:0] == 4'h8);
  c_err: cover property (pslverr);
  c_rise: cover property ($rose(counter_out[1]));
endmodule
bind ict_top ict_sva #(.NUM_CTR(NUM_CTR)) i_ict_sva (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clk_pin(count_clk_pin),
  .gate_input(gate_input), .counter_out(counter_out));

// ### verif/ict_host_model.sv
// Host side bus master that programs the counters
`timescale 1ns/1ps
module ict_host_model
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench of the interval counter timer
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  import ict_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  count_clk_pin = 3'h0;
  logic [2:0]  gate_input    = 3'h0;
  logic [2:0]  counter_out;
  int          error_cnt, samples_checked;
  always #10 ref_clk = ~ref_clk;
  ict_top i_ict_top (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_clk_pin(count_clk_pin), .gate_input(gate_input),
    .counter_out(counter_out));
  ict_host_model i_ict_host_model (.ref_clk(ref_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  // ****************
  // Helpers
  // ****************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ict_host_model.xfer(1'b1, a, d, rd, er);
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    i_ict_host_model.xfer(1'b0, a, 32'h0, rd, er);
    #1;
  endtask
  // Slow count clock, well under a quarter of ref_clk
  task automatic fall(input int i);
    @(posedge ref_clk);
    count_clk_pin[i] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    count_clk_pin[i] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic gate(input int i, input logic v);
    @(posedge ref_clk);
    gate_input[i] <= v;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rdr(8'h0C);
    `CHK(rd, 32'h0001_0000)
    rdr(8'h30);
    `CHK({er, rd}, {1'b1, 32'h0})
    rdr(8'h4C);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("t_reset done");
  endtask
  task automatic t_force();
    for (int i = 0; i < 3; i++)
    begin
      wr(8'(16 * i + 8), 32'h0);
      fall(i);
      `CHK(counter_out[i], 1'b0)
      rdr(8'(16 * i + 12));
      `CHK(rd[17:16], 2'b00)
      wr(8'(16 * i + 8), 32'h1);
      fall(i);
      `CHK(counter_out[i], 1'b1)
    end
    $display("t_force done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 6; m++)
    begin
      wr(8'h20, 32'(8 + m));
      `CHK(counter_out[2], m != 0)
    end
    $display("t_modes done");
  endtask
  task automatic t_mode0();
    gate(1, 1'b1);
    wr(8'h10, 32'h8);
    wr(8'h14, 32'h3);
    fall(1);
    rdr(8'h1C);
    `CHK(rd, 32'h0002_0003)
    fall(1);
    fall(1);
    `CHK(counter_out[1], 1'b0)
    gate(1, 1'b0);
    fall(1);
    rdr(8'h1C);
    `CHK(rd[15:0], 16'h0001)
    gate(1, 1'b1);
    fall(1);
    `CHK(counter_out[1], 1'b1)
    fall(1);
    `CHK(counter_out[1], 1'b1)
    $display("t_mode0 done");
  endtask
  task automatic t_mode4();
    gate(0, 1'b1);
    wr(8'h00, 32'hC);
    `CHK(counter_out[0], 1'b1)
    wr(8'h04, 32'h2);
    fall(0);
    fall(0);
    `CHK(counter_out[0], 1'b1)
    fall(0);
    `CHK(counter_out[0], 1'b0)
    fall(0);
    `CHK(counter_out[0], 1'b1)
    $display("t_mode4 done");
  endtask
  // Modes 1 and 5 hold the count until a gate rise
  task automatic t_trig();
    for (int m = 1; m < 6; m += 4)
    begin
      gate(0, 1'b0);
      wr(8'h00, 32'(8 + m));
      wr(8'h04, 32'h2);
      fall(0);
      fall(0);
      rdr(8'h0C);
      `CHK(rd, 32'h0003_0002)
      gate(0, 1'b1);
      fall(0);
      `CHK(counter_out[0], m == 5)
      fall(0);
      fall(0);
      `CHK(counter_out[0], m == 1)
    end
    $display("t_trig done");
  endtask
  task automatic t_format();
    logic [16:0] iv [5] = '{17'h10000, 17'h00000, 17'h00010, 17'h00100, 17'h10010};
    logic [15:0] ev [5] = '{16'hFFFF, 16'h9999, 16'h0009, 16'h0099, 16'h000F};
    gate(2, 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h20, {28'h0, iv[k][16], 3'h0});
      wr(8'h24, {16'h0, iv[k][15:0]});
      fall(2);
      fall(2);
      rdr(8'h2C);
      `CHK(rd[15:0], ev[k])
    end
    $display("t_format done");
  endtask
  // Low samples over whole periods, independent of phase
  task automatic t_periodic(input logic [2:0] m, input logic [15:0] c, input int f,
                            input int l);
    int n;
    n = 0;
    gate(1, 1'b1);
    wr(8'h10, {28'h0, 1'b1, m});
    wr(8'h14, {16'h0, c});
    fall(1);
    repeat (f)
    begin
      fall(1);
      if (counter_out[1] === 1'b0)
        n++;
    end
    `CHK(n, l)
    $display("t_periodic done");
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_force();
    t_modes();
    t_mode0();
    t_mode4();
    t_trig();
    t_format();
    t_periodic(3'h2, 16'h0003, 6, 2);
    t_periodic(3'h3, 16'h0004, 8, 4);
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    give_verdict();
  end
endmodule
